// file: afmt_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module afmt_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } afmt_fifo_s;

    afmt_fifo_s st_reg;
    afmt_fifo_s st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data = mem[st_reg.rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (do_wr) begin
            st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
        end
        if (do_rd) begin
            st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
        end
        if (do_wr && !do_rd) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (do_rd && !do_wr) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage has no reset; the count guards every read of it.
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[st_reg.wr_ptr] <= in_data;
        end
    end
endmodule : afmt_fifo
`default_nettype wire

// file: afmt_host_model.sv
// Host-side byte sink that rebuilds formatter words from the byte stream.
`timescale 1ns/1ps
`default_nettype none
module afmt_host_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] byte_data,
    input wire logic [1:0] byte_pos,
    input wire logic byte_valid,
    output logic byte_ready,
    input wire logic stall,
    input wire logic slow,
    output logic word_valid,
    output logic [23:0] word,
    output logic order_err
);
    logic [1:0] idx;
    logic [15:0] part;
    logic phase;
    // A slow host accepts only on every other cycle, so held bytes get exercised.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            byte_ready <= 1'b0;
            idx <= 2'h0;
            part <= 16'h0;
            phase <= 1'b0;
            word_valid <= 1'b0;
            word <= 24'h0;
            order_err <= 1'b0;
        end else begin
            phase <= ~phase;
            byte_ready <= !stall && (!slow || phase);
            word_valid <= 1'b0;
            if (byte_valid && byte_ready) begin
                if (byte_pos != idx) order_err <= 1'b1;
                if (idx == afmt_pkg::ACCEL_BYTE_LOW) begin
                    word <= {part, byte_data};
                    word_valid <= 1'b1;
                    idx <= 2'h0;
                end else begin
                    part <= {part[7:0], byte_data};
                    idx <= idx + 2'h1;
                end
            end
        end
    end
endmodule : afmt_host_model
`default_nettype wire

// file: afmt_pkg.sv
// Shared constants for the accelerometer output formatter.
package afmt_pkg;
    // Clock and internal sampling.
    localparam int CLK_HZ = 250_000_000;
    localparam int SAMPLE_RATE_HZ = 2000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
    // Continuous transmission rate and the resulting samples per average.
    localparam int CONT_TX_RATE_HZ = 500;
    localparam int CONT_AVG_SAMPLES = SAMPLE_RATE_HZ / CONT_TX_RATE_HZ;

    // Output unit codes.
    localparam logic [1:0] UNIT_ACCEL = 2'h0;
    localparam logic [1:0] UNIT_VEL = 2'h1;
    localparam logic [1:0] UNIT_AVG = 2'h2;

    // Range codes.
    localparam logic [2:0] RANGE_2G = 3'h0;
    localparam logic [2:0] RANGE_5G = 3'h1;
    localparam logic [2:0] RANGE_10G = 3'h2;
    localparam logic [2:0] RANGE_30G = 3'h3;
    localparam logic [2:0] RANGE_80G = 3'h4;

    // Acceleration scale exponents, counts per g are two to these powers.
    localparam int ACC_EXP_2G = 21;
    localparam int ACC_EXP_5G = 20;
    localparam int ACC_EXP_10G = 19;
    localparam int ACC_EXP_30G = 18;
    localparam int ACC_EXP_80G = 16;
    // Velocity scale exponents, counts per m/s are two to these powers.
    localparam int VEL_EXP_2G = 24;
    localparam int VEL_EXP_5G = 23;
    localparam int VEL_EXP_10G = 22;
    localparam int VEL_EXP_30G = 21;
    localparam int VEL_EXP_80G = 19;

    // Sample input is signed, in units of 2^-ACC_EXP_2G g.
    localparam int SAMPLE_W = 32;
    localparam int CNT_W = 16;
    localparam int SUM_W = 48;
    localparam int WORD_W = 24;
    localparam int WORK_W = 64;
    // Velocity factor 9.80665 / 2000 * 2^(VEL_EXP_2G - ACC_EXP_2G), in Q16.
    localparam int VEL_COEF_FRAC = 16;
    localparam logic [15:0] VEL_COEF = 16'h0a0b;
    localparam int FIFO_DEPTH = 4;

    // Byte positions within one 24-bit word.
    localparam logic [1:0] ACCEL_BYTE_HIGH = 2'h0;
    localparam logic [1:0] ACCEL_BYTE_MID = 2'h1;
    localparam logic [1:0] ACCEL_BYTE_LOW = 2'h2;
    localparam int BYTE_LAST_IDX = 2;

    typedef enum logic [2:0] {ST_IDLE, ST_DIV, ST_MUL, ST_SCALE, ST_PUSH} afmt_state_e;
endpackage : afmt_pkg

// file: afmt_top.sv
// Accelerometer output formatter for one axis: sampling, averaging, scaling, bytes.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each value is a 24-bit two's complement word sent high, middle, low byte.
// - Acceleration unit scales 2^21 counts per g at 2g, 2^20 at 5g.
// - Acceleration unit scales 2^19 at 10g, 2^18 at 30g, 2^16 at 80g.
// - Velocity unit gives change since last transmission, 2^24 counts per m/s at 2g, 2^23 at 5g.
// - Velocity unit scales 2^22 at 10g, 2^21 at 30g, 2^19 at 80g.
// - Average unit sends sum of samples since last transmission divided by their count.
// - Internal samples are taken at 2000 per second and feed the average.
// - Continuous transmission at 500 Hz averages exactly four internal samples.
// - Averaged values use the same range scaling and word format as acceleration.
module afmt_top #(
    parameter int SAMPLE_CYCLES = afmt_pkg::SAMPLE_CYCLES,
    parameter int FIFO_DEPTH = afmt_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic signed [afmt_pkg::SAMPLE_W-1:0] accel_in,
    input wire logic [1:0] cfg_unit,
    input wire logic [2:0] cfg_range,
    input wire logic tx_req,
    output logic tx_ready,
    output logic sample_tick,
    output logic [7:0] byte_data,
    output logic [1:0] byte_pos,
    output logic byte_valid,
    input wire logic byte_ready
);
    localparam int SW = afmt_pkg::SUM_W;
    localparam int CW = afmt_pkg::CNT_W;
    localparam int KW = afmt_pkg::WORK_W;
    localparam int WW = afmt_pkg::WORD_W;
    localparam int TW = $clog2(SAMPLE_CYCLES + 1);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic signed [SW-1:0] acc_sum;
        logic [CW-1:0] acc_cnt;
        logic signed [afmt_pkg::SAMPLE_W-1:0] latest;
        afmt_pkg::afmt_state_e state;
        logic [1:0] unit;
        logic [2:0] range;
        logic signed [SW-1:0] sum_l;
        logic [CW-1:0] cnt_l;
        logic [SW-1:0] dvd;
        logic [SW-1:0] rem;
        logic [5:0] bit_idx;
        logic neg;
        logic signed [KW-1:0] work;
        logic [WW-1:0] word;
        logic [WW-1:0] ser_word;
        logic [1:0] byte_pos;
        logic [7:0] byte_data;
        logic byte_valid;
        logic tx_ready;
    } afmt_s;

    afmt_s st_reg;
    afmt_s st_next;
    logic [1:0] rst_sync_reg;
    logic rst_n_int;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WW-1:0] fifo_out_data;
    logic take_tx;
    logic signed [SW-1:0] close_sum;
    logic [CW-1:0] close_cnt;
    logic [SW:0] div_trial;
    logic [SW-1:0] div_rem;
    logic [SW-1:0] quot;
    logic signed [KW-1:0] vel_prod;
    logic signed [KW-1:0] shifted;
    logic [WW-1:0] sat_word;
    logic [2:0] shift_amt;

    // The reset is released through two flops so every flop leaves reset on one edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    // The velocity scale follows the acceleration scale exactly, so one shift serves both.
    always_comb begin
        case (st_reg.range)
            afmt_pkg::RANGE_5G: shift_amt = 3'(afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_5G);
            afmt_pkg::RANGE_10G: shift_amt = 3'(afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_10G);
            afmt_pkg::RANGE_30G: shift_amt = 3'(afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_30G);
            afmt_pkg::RANGE_80G: shift_amt = 3'(afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_80G);
            default: shift_amt = 3'h0;
        endcase
    end

    assign take_tx = tx_req && st_reg.tx_ready;
    // A sample taken in the cycle of the request closes the old interval, none is lost.
    assign close_sum = st_reg.acc_sum + (st_reg.tick ? SW'(accel_in) : '0);
    assign close_cnt = st_reg.acc_cnt + (st_reg.tick ? CW'(1) : '0);
    assign div_trial = {st_reg.rem, st_reg.dvd[SW-1]} - {{(SW-CW+1){1'b0}}, st_reg.cnt_l};
    assign div_rem = div_trial[SW] ? {st_reg.rem[SW-2:0], st_reg.dvd[SW-1]} : div_trial[SW-1:0];
    assign quot = {st_reg.dvd[SW-2:0], ~div_trial[SW]};
    assign vel_prod = (KW'(st_reg.sum_l) * $signed({1'b0, afmt_pkg::VEL_COEF}))
                      >>> afmt_pkg::VEL_COEF_FRAC;
    assign shifted = st_reg.work >>> shift_amt;
    // Values beyond the word clamp rather than wrap, so a host never sees a sign flip.
    assign sat_word = (shifted > KW'(24'sh7fffff)) ? 24'h7fffff :
                      (shifted < -KW'(64'sh800000)) ? 24'h800000 : shifted[WW-1:0];
    assign fifo_out_ready = !st_reg.byte_valid;

    always_comb begin
        st_next = st_reg;
        // Internal sample clock.
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt == '0) begin
            st_next.tick_cnt = TW'(SAMPLE_CYCLES - 1);
            st_next.tick = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 1'b1;
        end
        // Accumulation of the samples since the last transmission.
        if (st_reg.tick) begin
            st_next.latest = accel_in;
            if (st_reg.acc_cnt != '1) begin
                st_next.acc_sum = close_sum;
                st_next.acc_cnt = close_cnt;
            end
        end
        case (st_reg.state)
            afmt_pkg::ST_IDLE: begin
                if (take_tx) begin
                    st_next.acc_sum = '0;
                    st_next.acc_cnt = '0;
                    st_next.unit = cfg_unit;
                    st_next.range = cfg_range;
                    st_next.sum_l = close_sum;
                    st_next.cnt_l = close_cnt;
                    st_next.tx_ready = 1'b0;
                    st_next.work = KW'(st_reg.tick ? accel_in : st_reg.latest);
                    if (cfg_unit == afmt_pkg::UNIT_AVG && close_cnt != '0) begin
                        st_next.neg = close_sum[SW-1];
                        st_next.dvd = close_sum[SW-1] ? -close_sum : close_sum;
                        st_next.rem = '0;
                        st_next.bit_idx = 6'(SW - 1);
                        st_next.state = afmt_pkg::ST_DIV;
                    end else if (cfg_unit == afmt_pkg::UNIT_VEL) begin
                        st_next.state = afmt_pkg::ST_MUL;
                    end else begin
                        st_next.state = afmt_pkg::ST_SCALE;
                    end
                end
            end
            afmt_pkg::ST_DIV: begin
                // Restoring division, one quotient bit a cycle, so any count is exact.
                st_next.rem = div_rem;
                st_next.dvd = quot;
                st_next.bit_idx = st_reg.bit_idx - 1'b1;
                if (st_reg.bit_idx == '0) begin
                    st_next.work = st_reg.neg ? -KW'(quot) : KW'(quot);
                    st_next.state = afmt_pkg::ST_SCALE;
                end
            end
            afmt_pkg::ST_MUL: begin
                st_next.work = vel_prod;
                st_next.state = afmt_pkg::ST_SCALE;
            end
            afmt_pkg::ST_SCALE: begin
                st_next.word = sat_word;
                st_next.state = afmt_pkg::ST_PUSH;
            end
            afmt_pkg::ST_PUSH: begin
                // A full FIFO holds the result here, which in turn holds off requests.
                if (fifo_in_ready) begin
                    st_next.state = afmt_pkg::ST_IDLE;
                    st_next.tx_ready = 1'b1;
                end
            end
            default: st_next.state = afmt_pkg::ST_IDLE;
        endcase
        // Byte serialiser, high byte first.
        if (st_reg.byte_valid && byte_ready) begin
            if (st_reg.byte_pos == 2'(afmt_pkg::BYTE_LAST_IDX)) begin
                st_next.byte_valid = 1'b0;
            end else begin
                st_next.byte_pos = st_reg.byte_pos + 1'b1;
                st_next.byte_data = (st_reg.byte_pos == afmt_pkg::ACCEL_BYTE_HIGH) ?
                                    st_reg.ser_word[15:8] : st_reg.ser_word[7:0];
            end
        end else if (!st_reg.byte_valid && fifo_out_valid) begin
            st_next.ser_word = fifo_out_data;
            st_next.byte_data = fifo_out_data[23:16];
            st_next.byte_pos = afmt_pkg::ACCEL_BYTE_HIGH;
            st_next.byte_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_reg <= '0;
            st_reg.state <= afmt_pkg::ST_IDLE;
            st_reg.tx_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    afmt_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_n_int),
        .in_valid(st_reg.state == afmt_pkg::ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(st_reg.word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign tx_ready = st_reg.tx_ready;
    assign sample_tick = st_reg.tick;
    assign byte_data = st_reg.byte_data;
    assign byte_pos = st_reg.byte_pos;
    assign byte_valid = st_reg.byte_valid;

    // Helper logic read only by the checks below.
    logic [TW:0] gap_reg;
    logic seen_tick_reg;
    logic [KW-1:0] chk_mag;
    logic [KW-1:0] chk_sum_mag;
    always_ff @(posedge mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            gap_reg <= '0;
            seen_tick_reg <= 1'b0;
        end else begin
            gap_reg <= st_reg.tick ? '0 : gap_reg + 1'b1;
            seen_tick_reg <= seen_tick_reg || st_reg.tick;
        end
    end
    assign chk_mag = st_next.work[KW-1] ? KW'(-st_next.work) : KW'(st_next.work);
    assign chk_sum_mag = st_reg.sum_l[SW-1] ? KW'(-st_reg.sum_l) : KW'(st_reg.sum_l);

    default clocking afmt_cb @(posedge mclk); endclocking
    default disable iff (!rst_n_int);

    AST_BYTE_HIGH_MID: assert property (
        byte_valid && byte_ready && byte_pos == afmt_pkg::ACCEL_BYTE_HIGH
        |=> byte_valid && byte_pos == afmt_pkg::ACCEL_BYTE_MID && byte_data == st_reg.ser_word[15:8])
        else $error("middle byte does not follow high byte");
    AST_BYTE_MID_LOW: assert property (
        byte_valid && byte_ready && byte_pos == afmt_pkg::ACCEL_BYTE_MID
        |=> byte_valid && byte_pos == afmt_pkg::ACCEL_BYTE_LOW && byte_data == st_reg.ser_word[7:0])
        else $error("low byte does not follow middle byte");
    AST_BYTE_HOLD: assert property (
        byte_valid && !byte_ready |=> byte_valid && $stable(byte_data) && $stable(byte_pos))
        else $error("byte changed while stalled");
    AST_TICK_PERIOD: assert property (
        sample_tick && seen_tick_reg |-> gap_reg == (TW+1)'(SAMPLE_CYCLES - 1))
        else $error("internal sample period wrong");
    AST_CLEAR_ON_TX: assert property (
        take_tx |=> st_reg.acc_cnt == '0 && st_reg.acc_sum == '0 && st_reg.cnt_l == $past(close_cnt))
        else $error("accumulator not cleared at transmission");
    AST_DIV_LENGTH: assert property (
        $rose(st_reg.state == afmt_pkg::ST_DIV) |-> ##48 st_reg.state == afmt_pkg::ST_SCALE)
        else $error("divider did not take 48 cycles");
    AST_AVG_QUOTIENT: assert property (
        st_reg.state == afmt_pkg::ST_DIV && st_reg.bit_idx == '0
        |-> chk_mag * KW'(st_reg.cnt_l) <= chk_sum_mag
            && chk_sum_mag < (chk_mag + 1'b1) * KW'(st_reg.cnt_l))
        else $error("average is not sum over count");
    AST_SCALE_2G: assert property (
        st_reg.state == afmt_pkg::ST_SCALE && st_reg.range == afmt_pkg::RANGE_2G
        && st_reg.work < KW'(24'sh7fffff) && st_reg.work > -KW'(24'sh7fffff)
        |=> st_reg.word == st_reg.work[WW-1:0]
            ##1 (st_reg.state == afmt_pkg::ST_IDLE || $past(fifo_in_ready) == 1'b0))
        else $error("2g scaling wrong");
    AST_SCALE_80G: assert property (
        st_reg.state == afmt_pkg::ST_SCALE && st_reg.range == afmt_pkg::RANGE_80G
        && st_reg.work[KW-1:29] == '0
        |=> st_reg.word == WW'(st_reg.work[28:5]))
        else $error("80g scaling wrong");

    COV_AVG_OF_FOUR: cover property (
        take_tx && cfg_unit == afmt_pkg::UNIT_AVG && close_cnt == CW'(afmt_pkg::CONT_AVG_SAMPLES));
    COV_VELOCITY: cover property (st_reg.state == afmt_pkg::ST_MUL);
    COV_FIFO_FULL: cover property (st_reg.state == afmt_pkg::ST_PUSH && !fifo_in_ready);
    COV_ODD_COUNT: cover property (take_tx && cfg_unit == afmt_pkg::UNIT_AVG && close_cnt == CW'(3));
endmodule : afmt_top
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the accelerometer output formatter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // A short sample period keeps the run brief; every expected word follows the monitor.
    localparam int SC = 20;
    logic mclk, rst_n, tx_req, tx_ready, sample_tick, byte_valid, byte_ready;
    logic signed [afmt_pkg::SAMPLE_W-1:0] accel_in;
    logic [1:0] cfg_unit, byte_pos;
    logic [2:0] cfg_range;
    logic [7:0] byte_data;
    logic stall, slow, ramp, word_valid, order_err, ok;
    logic [23:0] word;
    logic [23:0] exp_q[$];
    longint sum, last, n, last_n;
    int failures, total_checks, acc;

    afmt_top #(.SAMPLE_CYCLES(SC), .FIFO_DEPTH(afmt_pkg::FIFO_DEPTH)) dut (.mclk(mclk),
        .rst_n(rst_n), .accel_in(accel_in), .cfg_unit(cfg_unit), .cfg_range(cfg_range),
        .tx_req(tx_req), .tx_ready(tx_ready), .sample_tick(sample_tick),
        .byte_data(byte_data), .byte_pos(byte_pos), .byte_valid(byte_valid),
        .byte_ready(byte_ready));
    afmt_host_model host (.mclk(mclk), .rst_n(rst_n), .byte_data(byte_data),
        .byte_pos(byte_pos), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .stall(stall), .slow(slow), .word_valid(word_valid), .word(word),
        .order_err(order_err));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [23:0] fmt(input longint v, input logic [2:0] r);
        int e;
        case (r)
            afmt_pkg::RANGE_5G: e = afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_5G;
            afmt_pkg::RANGE_10G: e = afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_10G;
            afmt_pkg::RANGE_30G: e = afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_30G;
            afmt_pkg::RANGE_80G: e = afmt_pkg::ACC_EXP_2G - afmt_pkg::ACC_EXP_80G;
            default: e = 0;
        endcase
        v = v >>> e;
        if (v > 64'sh7fffff) return 24'h7fffff;
        if (v < -64'sh800000) return 24'h800000;
        return v[23:0];
    endfunction : fmt

    // Mirrors the sample stream; a tick in the take cycle closes with that interval.
    always @(posedge mclk) begin
        if (!rst_n) begin
            sum = 0;
            n = 0;
            last = 0;
        end else begin
            if (sample_tick === 1'b1) begin
                sum = sum + accel_in;
                n = n + 1;
                last = accel_in;
            end
            if (tx_req === 1'b1 && tx_ready === 1'b1) begin
                if (cfg_unit == afmt_pkg::UNIT_VEL)
                    exp_q.push_back(fmt((sum * longint'(afmt_pkg::VEL_COEF)) >>> 16, cfg_range));
                else if (cfg_unit == afmt_pkg::UNIT_AVG)
                    exp_q.push_back(fmt((n == 0) ? last : sum / n, cfg_range));
                else
                    exp_q.push_back(fmt(last, cfg_range));
                last_n = n;
                sum = 0;
                n = 0;
            end
        end
    end

    // Ramp alternates sign so averages of odd counts do not divide evenly.
    always @(posedge mclk) begin
        if (ramp && sample_tick === 1'b1) accel_in <= 32'sh0000_1234 - accel_in;
    end

    task automatic check(input string what, input logic [23:0] e, input logic [23:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : check

    always @(posedge mclk) begin
        if (word_valid === 1'b1) begin
            if (exp_q.size() == 0) check("word count", 24'h0, 24'h1);
            else check("word", exp_q.pop_front(), word);
        end
    end

    task automatic do_tx(input logic [1:0] u, input logic [2:0] r, input int lim, output logic got);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (tx_ready !== 1'b1 && k < lim);
        got = (tx_ready === 1'b1);
        if (got) begin
            cfg_unit <= u;
            cfg_range <= r;
            tx_req <= 1'b1;
            @(posedge mclk);
            tx_req <= 1'b0;
        end
    endtask : do_tx

    task automatic tx(input logic [1:0] u, input logic [2:0] r);
        do_tx(u, r, 300, ok);
        check("tx_ready", 24'h1, {23'h0, ok});
    endtask : tx

    task automatic drain(input string name);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        check("pending words", 24'h0, exp_q.size());
        check("byte order", 24'h0, {23'h0, order_err});
        $display("test %s done", name);
    endtask : drain

    task automatic test_accel;
        logic signed [31:0] vals[4] = '{32'sh0004_5678, -32'sh001e_dcbb, 32'sh0100_0000,
            -32'sh0200_0000};
        ramp = 1'b0;
        slow <= 1'b1;
        foreach (vals[i]) begin
            accel_in <= vals[i];
            repeat (SC + 2) @(posedge mclk);
            for (int r = 0; r < 6; r++) tx(afmt_pkg::UNIT_ACCEL, 3'(r));
            tx(2'h3, afmt_pkg::RANGE_10G);
        end
        drain("accel");
    endtask : test_accel

    task automatic test_vel;
        accel_in <= 32'sh0032_1001;
        ramp = 1'b1;
        slow <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            repeat (r * 7 + 25) @(posedge mclk);
            tx(afmt_pkg::UNIT_VEL, 3'(r));
        end
        tx(afmt_pkg::UNIT_VEL, afmt_pkg::RANGE_2G);
        tx(afmt_pkg::UNIT_VEL, afmt_pkg::RANGE_2G);
        drain("velocity");
    endtask : test_vel

    task automatic test_avg;
        tx(afmt_pkg::UNIT_AVG, afmt_pkg::RANGE_2G);
        for (int r = 0; r < 5; r++) begin
            repeat (4 * SC - 2) @(posedge mclk);
            tx(afmt_pkg::UNIT_AVG, 3'(r));
            #1 check("samples per average", 24'(afmt_pkg::CONT_AVG_SAMPLES), 24'(last_n));
        end
        repeat (3 * SC - 2) @(posedge mclk);
        tx(afmt_pkg::UNIT_AVG, afmt_pkg::RANGE_30G);
        #1 check("odd sample count", 24'h3, 24'(last_n));
        drain("average");
    endtask : test_avg

    task automatic test_fifo;
        ramp = 1'b0;
        stall <= 1'b1;
        acc = 0;
        for (int i = 0; i < 8; i++) begin
            do_tx(afmt_pkg::UNIT_ACCEL, 3'(i % 5), 40, ok);
            acc += ok;
        end
        // The full buffer must refuse further requests while the host stalls.
        check("fifo refusal", 24'h1, {23'h0, acc >= afmt_pkg::FIFO_DEPTH && acc < 8});
        stall <= 1'b0;
        drain("fifo");
    endtask : test_fifo

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        $display("BAD watchdog expected done seen hang");
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        accel_in = 32'sh0;
        cfg_unit = 2'h0;
        cfg_range = 3'h0;
        tx_req = 1'b0;
        stall = 1'b0;
        slow = 1'b0;
        ramp = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        test_accel();
        test_vel();
        test_avg();
        test_fifo();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
